//--- hdl/qtr_defines.svh
// Register indices, field positions, reset values and timing constants of the timer block
`ifndef QTR_DEFINES_SVH
`define QTR_DEFINES_SVH
`define QTR_IDX_W 6
`define QTR_IDX_CTRL0 6'h05
`define QTR_IDX_T0_LOW 6'h0B
`define QTR_IDX_T0_HIGH 6'h0C
`define QTR_IDX_MODE 6'h10
`define QTR_IDX_FLAGS 6'h11
`define QTR_IDX_T1 6'h12
`define QTR_IDX_T2 6'h13
`define QTR_IDX_PER1 6'h14
`define QTR_IDX_PER2 6'h15
`define QTR_IDX_T3_LOW 6'h16
`define QTR_IDX_T3_HIGH 6'h17
`define QTR_IDX_PER3_LOW 6'h18
`define QTR_IDX_PER3_HIGH 6'h19
`define QTR_IDX_CAP2_LOW 6'h1A
`define QTR_IDX_CAP2_HIGH 6'h1B
`define QTR_IDX_DUTY1 6'h1C
`define QTR_IDX_DUTY2 6'h1D
`define QTR_BYTE_LANE_ZERO 2'h0
`define QTR_B_EDGE 6
`define QTR_B_CSEL 5
`define QTR_B_PS_TOP 4
`define QTR_B_PS_HI 3
`define QTR_B_PS_LO 1
`define QTR_CTRL_MASK 8'hFE
`define QTR_CTRL_RESET 8'h00
`define QTR_M_T1_EXT 0
`define QTR_M_T2_EXT 1
`define QTR_M_T3_EXT 2
`define QTR_M_JOIN 3
`define QTR_M_T1_RUN 4
`define QTR_M_T2_RUN 5
`define QTR_M_T3_RUN 6
`define QTR_M_DUAL 7
`define QTR_F_T0 0
`define QTR_F_T1 1
`define QTR_F_T2 2
`define QTR_F_T3 3
`define QTR_NPINS 5
`define QTR_PIN_T0 0
`define QTR_PIN_SHARED 1
`define QTR_PIN_FOURTH 2
`define QTR_PIN_CAP1 3
`define QTR_PIN_CAP2 4
`define QTR_INST_DIV 4
`define QTR_PRE_ONE 9'h001
`define QTR_PRE_FULL 9'h100
`define QTR_MAX16 16'hFFFF
`endif

//--- hdl/qtr_pkg.sv
// Shared types of the timer block
package qtr_pkg;
  typedef logic [7:0] qtr_byte_t;
  typedef logic [15:0] qtr_word_t;
  typedef enum logic {QTR_SRC_EXT = 1'b0, QTR_SRC_INT = 1'b1} qtr_src_e;
endpackage

//--- hdl/qtr_top.sv
// Four timers with prescaler, captures and PWM time-bases behind an APB slave
//
// Notes on behaviour
// - First timer is 16 bits, seen as separate low and high byte registers.
// - An 8-bit prescaler precedes the first timer, giving 24-bit overflow reach.
// - Control bit 5 high picks instruction clock, low picks external pin.
// - Field bits 4..1: codes 0..7 divide by 1..128, any 1xxx divides by 256.
// - With external clock, control bit 6 picks the counted pin edge.
// - Edge bit set counts rising pin edges, clear counts falling edges.
// - Control bit 0 is unimplemented and always reads zero.
// - Reset clears every implemented control bit.
// - Pin edges are aligned to instruction cycles after the prescaler.
// - Internal source is system clock divided by four, one per instruction.
// - First timer counts 0000h..FFFFh, wraps, and sets its flag on wrap.
// - Any write to either first timer byte clears the prescaler.
// - Second timer wraps from its period to zero and sets its flag.
// - Third timer wraps from its own period to zero and sets its flag.
// - Second and third timers may count the shared external pin.
// - Joined mode: second is low byte, third high, against joined period.
// - Joined mode wrap sets the second timer's flag, not the third's.
// - Fourth timer is 16 bits, wraps at its period (at FFFFh in dual capture mode) and sets its flag.
// - Fourth timer may count its own dedicated external pin.
// - Dual capture mode turns the fourth period register into a capture.
// - Second and third drive the PWM outputs; fourth feeds the captures.
`timescale 1ns/1ps
`include "qtr_defines.svh"
module qtr_top
  import qtr_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_FIRST_TIMER_CLOCK_PIN,
  input wire logic I_SHARED_COUNTER_PIN,
  input wire logic I_FOURTH_COUNTER_PIN,
  input wire logic I_CAPTURE1_PIN,
  input wire logic I_CAPTURE2_PIN,
  output logic O_PWM1,
  output logic O_PWM2,
  output logic [3:0] O_FLAGS
);

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RSTN);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  qtr_byte_t first_timer_control, mode, second_timer_count, third_timer_count;
  qtr_byte_t second_timer_period, third_timer_period, duty1, duty2;
  qtr_word_t first_timer_count, fourth_timer_count, fourth_period, capture2;
  logic [3:0] flags;
  logic [3:0] ev;
  logic [1:0] inst_div;
  logic [`QTR_NPINS-1:0] pin_meta, pin_sync, pin_prev, pin_rise, pin_fall;
  logic [7:0] pre_cnt;
  logic [7:0] wdat;
  logic [8:0] pre_ratio;
  logic [`QTR_IDX_W-1:0] idx;
  logic [31:0] rd_val;
  logic inst_tick, pre_src, pre_out, t0_pend, t0_inc, t1_inc, t2_inc, t3_inc;
  logic lane_ok, wr, wr_t0, wr_t1, wr_t2, wr_t3, rd_hit, joined, dual;
  qtr_src_e t0_src;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign idx = I_PADDR[7:2];
  assign lane_ok = (I_PADDR[1:0] == `QTR_BYTE_LANE_ZERO);
  assign wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && rd_hit;
  // Only a write to a timer's own bytes may cancel its count or wrap
  assign wr_t0 = wr && (idx == `QTR_IDX_T0_LOW || idx == `QTR_IDX_T0_HIGH);
  assign wr_t1 = wr && (idx == `QTR_IDX_T1);
  assign wr_t2 = wr && (idx == `QTR_IDX_T2);
  assign wr_t3 = wr && (idx == `QTR_IDX_T3_LOW || idx == `QTR_IDX_T3_HIGH);
  assign wdat = I_PWDATA[7:0];
  assign joined = mode[`QTR_M_JOIN];
  assign dual = mode[`QTR_M_DUAL];
  assign t0_src = qtr_src_e'(first_timer_control[`QTR_B_CSEL]);

  // Read mux; narrow registers sit in the low bits, upper bits read zero
  always_comb
  begin
    rd_val = '0;
    rd_hit = lane_ok;
    case (idx)
      `QTR_IDX_CTRL0: rd_val[7:0] = first_timer_control & `QTR_CTRL_MASK;
      `QTR_IDX_T0_LOW: rd_val[7:0] = first_timer_count[7:0];
      `QTR_IDX_T0_HIGH: rd_val[7:0] = first_timer_count[15:8];
      `QTR_IDX_MODE: rd_val[7:0] = mode;
      `QTR_IDX_FLAGS: rd_val[3:0] = flags;
      `QTR_IDX_T1: rd_val[7:0] = second_timer_count;
      `QTR_IDX_T2: rd_val[7:0] = third_timer_count;
      `QTR_IDX_PER1: rd_val[7:0] = second_timer_period;
      `QTR_IDX_PER2: rd_val[7:0] = third_timer_period;
      `QTR_IDX_T3_LOW: rd_val[7:0] = fourth_timer_count[7:0];
      `QTR_IDX_T3_HIGH: rd_val[7:0] = fourth_timer_count[15:8];
      `QTR_IDX_PER3_LOW: rd_val[7:0] = fourth_period[7:0];
      `QTR_IDX_PER3_HIGH: rd_val[7:0] = fourth_period[15:8];
      `QTR_IDX_CAP2_LOW: rd_val[7:0] = capture2[7:0];
      `QTR_IDX_CAP2_HIGH: rd_val[7:0] = capture2[15:8];
      `QTR_IDX_DUTY1: rd_val[7:0] = duty1;
      `QTR_IDX_DUTY2: rd_val[7:0] = duty2;
      default: rd_hit = 1'b0;
    endcase
  end

  // No wait state: answer is built in setup so every bus output is a flop
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_PREADY <= 1'b0;
      O_PRDATA <= '0;
      O_PSLVERR <= 1'b0;
    end
    else if (I_PSEL && !I_PENABLE)
    begin
      O_PREADY <= 1'b1;
      O_PRDATA <= (I_PWRITE || !rd_hit) ? '0 : rd_val;
      O_PSLVERR <= !rd_hit;
    end
    else
    begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction clock: system clock divided by four
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      inst_div <= '0;
    else
      inst_div <= inst_div + 2'(1);
  end
  assign inst_tick = (inst_div == 2'(`QTR_INST_DIV - 1));

  sequence s_tick_gap;
    !inst_tick [*3] ##1 inst_tick;
  endsequence
  property p_inst_period;
    inst_tick |=> s_tick_gap;
  endproperty
  a_inst_period: assert property (p_inst_period)
    else $error("instruction tick not one in four clocks");

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detectors, read only after the second flop
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end
    else
    begin
      pin_meta <= {I_CAPTURE2_PIN, I_CAPTURE1_PIN, I_FOURTH_COUNTER_PIN,
                   I_SHARED_COUNTER_PIN, I_FIRST_TIMER_CLOCK_PIN};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; bit 0 is never stored
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      first_timer_control <= `QTR_CTRL_RESET;
    else if (wr && idx == `QTR_IDX_CTRL0)
      first_timer_control <= wdat & `QTR_CTRL_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler source: instruction tick or chosen edge of the pin
  always_comb
  begin
    if (t0_src == QTR_SRC_INT)
      pre_src = inst_tick;
    else if (first_timer_control[`QTR_B_EDGE])
      pre_src = pin_rise[`QTR_PIN_T0];
    else
      pre_src = pin_fall[`QTR_PIN_T0];
  end

  // Division ratio from the prescale field
  assign pre_ratio = first_timer_control[`QTR_B_PS_TOP] ? `QTR_PRE_FULL
    : (`QTR_PRE_ONE << first_timer_control[`QTR_B_PS_HI:`QTR_B_PS_LO]);
  assign pre_out = pre_src && ({1'b0, pre_cnt} == pre_ratio - `QTR_PRE_ONE);

  property p_ratio_full;
    first_timer_control[`QTR_B_PS_TOP] |-> pre_ratio == `QTR_PRE_FULL;
  endproperty
  a_ratio_full: assert property (p_ratio_full)
    else $error("prescale code 1xxx does not divide by 256");

  // Prescale counter; a byte write to the first timer restarts it
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      pre_cnt <= '0;
    else if (wr && (idx == `QTR_IDX_T0_LOW || idx == `QTR_IDX_T0_HIGH))
      pre_cnt <= '0;
    else if (pre_out)
      pre_cnt <= '0;
    else if (pre_src)
      pre_cnt <= pre_cnt + 8'(1);
  end

  property p_pre_clear;
    (wr && (idx == `QTR_IDX_T0_LOW || idx == `QTR_IDX_T0_HIGH)) |=> pre_cnt == '0;
  endproperty
  a_pre_clear: assert property (p_pre_clear)
    else $error("byte write left prescaler uncleared");

  // Prescaler output waits for the next instruction cycle; pin jitter stays upstream
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      t0_pend <= 1'b0;
    else
      t0_pend <= (t0_pend || pre_out) && !inst_tick;
  end
  assign t0_inc = inst_tick && (t0_pend || pre_out);

  ////////////////////////////////////////////////////////////////////////////
  // First timer: write of a byte wins over the count in that cycle
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      first_timer_count <= '0;
    else if (wr && idx == `QTR_IDX_T0_LOW)
      first_timer_count[7:0] <= wdat;
    else if (wr && idx == `QTR_IDX_T0_HIGH)
      first_timer_count[15:8] <= wdat;
    else if (t0_inc)
      first_timer_count <= first_timer_count + 16'(1);
  end

  property p_t0_step;
    (t0_inc && !wr_t0) |=> first_timer_count == $past(first_timer_count) + 16'(1);
  endproperty
  a_t0_step: assert property (p_t0_step)
    else $error("first timer did not step by one");

  ////////////////////////////////////////////////////////////////////////////
  // Mode, periods and duty registers
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      mode <= '0;
      second_timer_period <= '0;
      third_timer_period <= '0;
      duty1 <= '0;
      duty2 <= '0;
    end
    else if (wr)
    begin
      case (idx)
        `QTR_IDX_MODE: mode <= wdat;
        `QTR_IDX_PER1: second_timer_period <= wdat;
        `QTR_IDX_PER2: third_timer_period <= wdat;
        `QTR_IDX_DUTY1: duty1 <= wdat;
        `QTR_IDX_DUTY2: duty2 <= wdat;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count enables of the second, third and fourth timers
  assign t1_inc = mode[`QTR_M_T1_RUN] && (mode[`QTR_M_T1_EXT]
    ? pin_fall[`QTR_PIN_SHARED] : inst_tick);
  assign t2_inc = mode[`QTR_M_T2_RUN] && (mode[`QTR_M_T2_EXT]
    ? pin_fall[`QTR_PIN_SHARED] : inst_tick);
  assign t3_inc = mode[`QTR_M_T3_RUN] && (mode[`QTR_M_T3_EXT]
    ? pin_fall[`QTR_PIN_FOURTH] : inst_tick);

  // Wrap events; a write to the counting register cancels that event
  always_comb
  begin
    ev = '0;
    ev[`QTR_F_T0] = t0_inc && !wr_t0 && (first_timer_count == `QTR_MAX16);
    if (joined)
      ev[`QTR_F_T1] = t1_inc && !(wr_t1 || wr_t2) && ({third_timer_count, second_timer_count}
        == {third_timer_period, second_timer_period});
    else
    begin
      ev[`QTR_F_T1] = t1_inc && !wr_t1 && (second_timer_count == second_timer_period);
      ev[`QTR_F_T2] = t2_inc && !wr_t2 && (third_timer_count == third_timer_period);
    end
    ev[`QTR_F_T3] = t3_inc && !wr_t3 && (dual ? (fourth_timer_count == `QTR_MAX16)
      : (fourth_timer_count == fourth_period));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second and third timers, alone or joined as one 16-bit timer
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      second_timer_count <= '0;
      third_timer_count <= '0;
    end
    else if (joined && (wr_t1 || wr_t2))
    begin
      // Joined pair holds its other byte while software writes one
      if (wr_t1)
        second_timer_count <= wdat;
      if (wr_t2)
        third_timer_count <= wdat;
    end
    else if (joined)
    begin
      if (ev[`QTR_F_T1])
      begin
        second_timer_count <= '0;
        third_timer_count <= '0;
      end
      else if (t1_inc)
        {third_timer_count, second_timer_count} <=
          {third_timer_count, second_timer_count} + 16'(1);
    end
    else
    begin
      if (wr_t1)
        second_timer_count <= wdat;
      else if (ev[`QTR_F_T1])
        second_timer_count <= '0;
      else if (t1_inc)
        second_timer_count <= second_timer_count + 8'(1);
      if (wr_t2)
        third_timer_count <= wdat;
      else if (ev[`QTR_F_T2])
        third_timer_count <= '0;
      else if (t2_inc)
        third_timer_count <= third_timer_count + 8'(1);
    end
  end

  property p_t1_wrap;
    (!joined && ev[`QTR_F_T1]) |=> second_timer_count == '0 && flags[`QTR_F_T1];
  endproperty
  a_t1_wrap: assert property (p_t1_wrap)
    else $error("second timer did not wrap to zero with flag");

  property p_join_wrap;
    (joined && ev[`QTR_F_T1] && !flags[`QTR_F_T2])
      |=> {third_timer_count, second_timer_count} == '0 && flags[`QTR_F_T1]
      && !flags[`QTR_F_T2];
  endproperty
  a_join_wrap: assert property (p_join_wrap)
    else $error("joined wrap did not set only the second flag");

  ////////////////////////////////////////////////////////////////////////////
  // Fourth timer, its period or first capture, and the second capture
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      fourth_timer_count <= '0;
    else if (wr && idx == `QTR_IDX_T3_LOW)
      fourth_timer_count[7:0] <= wdat;
    else if (wr && idx == `QTR_IDX_T3_HIGH)
      fourth_timer_count[15:8] <= wdat;
    else if (ev[`QTR_F_T3])
      fourth_timer_count <= '0;
    else if (t3_inc)
      fourth_timer_count <= fourth_timer_count + 16'(1);
  end

  // Capture edges take the fourth count; software writes win
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      fourth_period <= '0;
      capture2 <= '0;
    end
    else
    begin
      if (wr && idx == `QTR_IDX_PER3_LOW)
        fourth_period[7:0] <= wdat;
      else if (wr && idx == `QTR_IDX_PER3_HIGH)
        fourth_period[15:8] <= wdat;
      else if (dual && pin_rise[`QTR_PIN_CAP1])
        fourth_period <= fourth_timer_count;
      if (wr && idx == `QTR_IDX_CAP2_LOW)
        capture2[7:0] <= wdat;
      else if (wr && idx == `QTR_IDX_CAP2_HIGH)
        capture2[15:8] <= wdat;
      else if (pin_rise[`QTR_PIN_CAP2])
        capture2 <= fourth_timer_count;
    end
  end

  property p_t3_wrap;
    ev[`QTR_F_T3] |=> fourth_timer_count == '0 && flags[`QTR_F_T3];
  endproperty
  a_t3_wrap: assert property (p_t3_wrap)
    else $error("fourth timer did not wrap to zero with flag");

  property p_dual_capture;
    (dual && pin_rise[`QTR_PIN_CAP1] && !wr)
      |=> fourth_period == $past(fourth_timer_count);
  endproperty
  a_dual_capture: assert property (p_dual_capture)
    else $error("dual capture missed the fourth count");

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      flags <= '0;
    else if (wr && idx == `QTR_IDX_FLAGS)
      flags <= (flags & ~I_PWDATA[3:0]) | ev;
    else
      flags <= flags | ev;
  end

  property p_t0_wrap;
    ev[`QTR_F_T0] |=> first_timer_count == '0 && flags[`QTR_F_T0];
  endproperty
  a_t0_wrap: assert property (p_t0_wrap)
    else $error("first timer wrap lost count or flag");

  ////////////////////////////////////////////////////////////////////////////
  // PWM outputs time-based on the second and third timers; flag mirror
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_PWM1 <= 1'b0;
      O_PWM2 <= 1'b0;
      O_FLAGS <= '0;
    end
    else
    begin
      O_PWM1 <= mode[`QTR_M_T1_RUN] && (second_timer_count < duty1);
      O_PWM2 <= mode[`QTR_M_T2_RUN] && (third_timer_count < duty2);
      O_FLAGS <= flags;
    end
  end

  property p_ctrl_read;
    (I_PSEL && !I_PENABLE && !I_PWRITE && lane_ok && idx == `QTR_IDX_CTRL0)
      |=> O_PREADY && O_PRDATA[0] == 1'b0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control bit 0 read as one");

  property p_int_source;
    (t0_src == QTR_SRC_INT && inst_tick) |-> pre_src;
  endproperty
  a_int_source: assert property (p_int_source)
    else $error("internal source did not feed the prescaler");

endmodule

//--- dv/qtr_pin_src.sv
// Model of the external clock, count and capture sources at the timer pins
`timescale 1ns/1ps
module qtr_pin_src
(
  input wire logic i_clk,
  output logic o_first_pin,
  output logic o_shared_pin,
  output logic o_fourth_pin,
  output logic o_cap1_pin,
  output logic o_cap2_pin
);
  logic [4:0] pins = 5'h00;

  ////////////////////////////////////////////////////////////
  // Pin order: first, shared, fourth, capture 1, capture 2
  assign o_first_pin = pins[0];
  assign o_shared_pin = pins[1];
  assign o_fourth_pin = pins[2];
  assign o_cap1_pin = pins[3];
  assign o_cap2_pin = pins[4];

  ////////////////////////////////////////////////////////////
  // Levels move just after an edge; two clocks minimum keeps pulses visible
  task automatic set_pin(input int idx, input logic lvl, input int hold);
    @(posedge i_clk);
    pins[idx] <= lvl;
    repeat ((hold < 2) ? 2 : hold) @(posedge i_clk);
  endtask

  // Full pulses away from the rest level and back
  task automatic pulses(input int idx, input int n, input int hold);
    repeat (n)
    begin
      set_pin(idx, ~pins[idx], hold);
      set_pin(idx, ~pins[idx], hold);
    end
  endtask
endmodule

//--- dv/qtr_top_tb.sv
// Self-checking bench for the timer block
`timescale 1ns/1ps
`include "qtr_defines.svh"
module qtr_top_tb;
  typedef struct {logic err; logic [31:0] d; logic [31:0] m;} qtr_exp_s;
  qtr_exp_s exp_q[$];
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0] flags;
  logic pready, pslverr, pwm1, pwm2, t0p, shp, t3p, c1p, c2p;
  int err_count = 0;
  int checks = 0;
  int r;

  ////////////////////////////////////////////////////////////
  // 50 MHz system clock
  initial
    forever #10 clk = ~clk;

  qtr_top u_dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_FIRST_TIMER_CLOCK_PIN(t0p),
    .I_SHARED_COUNTER_PIN(shp), .I_FOURTH_COUNTER_PIN(t3p), .I_CAPTURE1_PIN(c1p),
    .I_CAPTURE2_PIN(c2p), .O_PWM1(pwm1), .O_PWM2(pwm2), .O_FLAGS(flags));

  qtr_pin_src u_src (.i_clk(clk), .o_first_pin(t0p), .o_shared_pin(shp),
    .o_fourth_pin(t3p), .o_cap1_pin(c1p), .o_cap2_pin(c2p));

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // One APB transfer; the expectation is queued for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
                     input logic e, input logic [31:0] ed, input logic [31:0] m);
    int n;
    exp_q.push_back('{e, ed, m});
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      summarize();
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d, 1'b0, 32'h0, 32'h0);
  endtask

  task automatic rdc(input logic [5:0] i, input logic [7:0] d);
    apb(1'b0, {i, 2'b00}, 8'h00, 1'b0, {24'h000000, d}, 32'hFFFFFFFF);
  endtask

  // Sync flops plus the wait for an instruction tick
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // Free-running count on the instruction clock over a fixed window
  task automatic itick(input logic [7:0] ctl, input logic [31:0] lo, input logic [31:0] hi);
    wr(`QTR_IDX_CTRL0, ctl);
    wr(`QTR_IDX_T0_LOW, 8'h00);
    wr(`QTR_IDX_T0_HIGH, 8'h00);
    repeat (400) @(posedge clk);
    wr(`QTR_IDX_CTRL0, 8'h00);
    apb(1'b0, {`QTR_IDX_T0_LOW, 2'b00}, 8'h00, 1'b0, 32'h0, 32'h0);
    check({31'h0, (rd >= lo && rd <= hi)}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////
  // Monitor: every answered transfer takes the oldest note
  always @(posedge clk)
    if (psel && pen && pready === 1'b1)
    begin
      qtr_exp_s x;
      x = exp_q.pop_front();
      checks++;
      if (pslverr !== x.err || (prdata & x.m) !== (x.d & x.m))
      begin
        $display("unexpected at %0t: got %h expected %h", $time, prdata, x.d);
        err_count++;
      end
    end

  ////////////////////////////////////////////////////////////
  initial
  begin
    r = $urandom(32'hA6F7);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({26'h0, pwm1, pwm2, flags}, 32'h0);
    rdc(`QTR_IDX_CTRL0, 8'h00);
    rdc(`QTR_IDX_T0_HIGH, 8'h00);
    // Random control values; bit 0 never sticks
    repeat (4)
    begin
      r = $urandom;
      wr(`QTR_IDX_CTRL0, r[7:0]);
      rdc(`QTR_IDX_CTRL0, r[7:0] & 8'hFE);
    end
    wr(`QTR_IDX_CTRL0, 8'h00);
    apb(1'b0, 8'hFC, 8'h00, 1'b1, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, 8'h15, 8'hAA, 1'b1, 32'h0, 32'h0);
    rdc(`QTR_IDX_CTRL0, 8'h00);
    // Edge select: rising first, then falling
    for (int e = 1; e >= 0; e--)
    begin
      wr(`QTR_IDX_CTRL0, e[0] ? 8'h40 : 8'h00);
      wr(`QTR_IDX_T0_LOW, 8'h00);
      u_src.set_pin(0, 1'b1, 5);
      settle();
      rdc(`QTR_IDX_T0_LOW, {7'h00, e[0]});
      u_src.set_pin(0, 1'b0, 5);
      settle();
      rdc(`QTR_IDX_T0_LOW, 8'h01);
    end
    // Every prescale ratio, codes 0..8 and 15, two outputs' worth of edges each
    for (int c = 0; c < 10; c++)
    begin
      int k;
      k = (c > 8) ? 15 : c;
      wr(`QTR_IDX_CTRL0, 8'h40 | (k[7:0] << 1));
      wr(`QTR_IDX_T0_LOW, 8'h00);
      wr(`QTR_IDX_T0_HIGH, 8'h00);
      u_src.pulses(0, 2 << ((k > 7) ? 8 : k), c[0] ? 4 : 2);
      settle();
      rdc(`QTR_IDX_T0_LOW, 8'h02);
      rdc(`QTR_IDX_T0_HIGH, 8'h00);
    end
    // A counter write drops a half-filled prescale
    wr(`QTR_IDX_CTRL0, 8'h42);
    wr(`QTR_IDX_T0_LOW, 8'h00);
    u_src.pulses(0, 1, 2);
    wr(`QTR_IDX_T0_LOW, 8'h00);
    u_src.pulses(0, 1, 2);
    settle();
    rdc(`QTR_IDX_T0_LOW, 8'h00);
    u_src.pulses(0, 1, 2);
    settle();
    rdc(`QTR_IDX_T0_LOW, 8'h01);
    // Wrap from all ones
    wr(`QTR_IDX_CTRL0, 8'h40);
    wr(`QTR_IDX_FLAGS, 8'h0F);
    wr(`QTR_IDX_T0_LOW, 8'hFF);
    wr(`QTR_IDX_T0_HIGH, 8'hFF);
    u_src.pulses(0, 1, 2);
    settle();
    rdc(`QTR_IDX_T0_HIGH, 8'h00);
    rdc(`QTR_IDX_FLAGS, 8'h01);
    check({28'h0, flags}, 32'h1);
    wr(`QTR_IDX_FLAGS, 8'h01);
    rdc(`QTR_IDX_FLAGS, 8'h00);
    itick(8'h20, 32'd100, 32'd103);
    itick(8'h24, 32'd24, 32'd26);
    // Second and third timers on the shared pin
    wr(`QTR_IDX_PER1, 8'h02);
    wr(`QTR_IDX_PER2, 8'h05);
    wr(`QTR_IDX_MODE, 8'h33);
    u_src.pulses(1, 3, 2);
    settle();
    rdc(`QTR_IDX_T1, 8'h00);
    rdc(`QTR_IDX_T2, 8'h03);
    rdc(`QTR_IDX_FLAGS, 8'h02);
    u_src.pulses(1, 3, 4);
    settle();
    rdc(`QTR_IDX_T2, 8'h00);
    rdc(`QTR_IDX_FLAGS, 8'h06);
    check({28'h0, flags}, 32'h6);
    // Joined pair against period 0102h
    wr(`QTR_IDX_MODE, 8'h19);
    wr(`QTR_IDX_T1, 8'h00);
    wr(`QTR_IDX_T2, 8'h00);
    wr(`QTR_IDX_PER2, 8'h01);
    wr(`QTR_IDX_FLAGS, 8'h0F);
    u_src.pulses(1, 258, 2);
    settle();
    rdc(`QTR_IDX_T1, 8'h02);
    rdc(`QTR_IDX_T2, 8'h01);
    rdc(`QTR_IDX_FLAGS, 8'h00);
    u_src.pulses(1, 1, 2);
    settle();
    rdc(`QTR_IDX_T2, 8'h00);
    rdc(`QTR_IDX_FLAGS, 8'h02);
    // Duty compare on the second and third timers
    wr(`QTR_IDX_MODE, 8'h30);
    wr(`QTR_IDX_DUTY1, 8'hFF);
    wr(`QTR_IDX_DUTY2, 8'hFF);
    repeat (4) @(posedge clk);
    check({31'h0, pwm1}, 32'h1);
    check({31'h0, pwm2}, 32'h1);
    wr(`QTR_IDX_DUTY1, 8'h00);
    wr(`QTR_IDX_DUTY2, 8'h00);
    repeat (4) @(posedge clk);
    check({31'h0, pwm1}, 32'h0);
    check({31'h0, pwm2}, 32'h0);
    // Fourth timer on its own pin, then captures
    wr(`QTR_IDX_MODE, 8'h44);
    wr(`QTR_IDX_PER3_LOW, 8'h03);
    wr(`QTR_IDX_PER3_HIGH, 8'h00);
    wr(`QTR_IDX_FLAGS, 8'h0F);
    u_src.pulses(2, 4, 3);
    settle();
    rdc(`QTR_IDX_T3_LOW, 8'h00);
    rdc(`QTR_IDX_FLAGS, 8'h08);
    u_src.pulses(2, 2, 2);
    wr(`QTR_IDX_MODE, 8'hC4);
    u_src.set_pin(3, 1'b1, 2);
    u_src.set_pin(4, 1'b1, 2);
    settle();
    rdc(`QTR_IDX_PER3_LOW, 8'h02);
    rdc(`QTR_IDX_CAP2_LOW, 8'h02);
    summarize();
  end
endmodule
